// file: hw/hkw_regs.svh
// Constants for the hot-key wake and analog switch control block.
// Assumes a byte-wide register port decoded by the device's serial bus slave.
`ifndef HKW_REGS_SVH
`define HKW_REGS_SVH

`define HKW_OFS_SWITCH_CTRL   8'hA1
`define HKW_OFS_LEGACY_CTRL   8'hA5
`define HKW_SW1_SEL_BIT       0
`define HKW_SW1_DIS_BIT       1
`define HKW_SW2_SEL_BIT       2
`define HKW_SW2_DIS_BIT       3
`define HKW_LEGACY_BIT        0
`define HKW_SWITCH_RESET      8'h00
`define HKW_LEGACY_RESET      8'h00
`define HKW_SWITCH_RW_MASK    8'h0F
`define HKW_LEGACY_RW_MASK    8'h01
`define HKW_MIN_PULSE_NS      62500
`define HKW_CLK_PERIOD_NS     8
`define HKW_MIN_PULSE_CYC     ((`HKW_MIN_PULSE_NS + `HKW_CLK_PERIOD_NS - 1) / `HKW_CLK_PERIOD_NS)

`endif

// file: hw/hkw_pkg.sv
// Types shared by the hot-key wake block.
// Assumes the constants header is included by the design files.
`default_nettype none
package hkw_pkg;
    typedef enum logic [1:0] {
        HKW_AWAKE    = 2'b00,
        HKW_ASLEEP   = 2'b01,
        HKW_WAKING   = 2'b10
    } hkw_power_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hkw_reg_req_s;

    typedef struct packed {
        logic [3:0] col;
        logic [3:0] row;
    } hkw_keypad_s;
endpackage
`default_nettype wire

// file: hw/hkw_pin_sync.sv
// Three-stage synchroniser for one wake-key pin with edge detection.
// Assumes the pin is asynchronous to ref_clk.
`default_nettype none
module hkw_pin_sync (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    // A change counts once stages two and three agree.
    wire agree     = (s2_r == s3_r);
    wire level_nxt = agree ? s3_r : level_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r    <= pin_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level = level_r;
    assign rise  = level_nxt & ~level_r;
    assign fall  = ~level_nxt & level_r;
endmodule
`default_nettype wire

// file: hw/hkw_top.sv
// Hot-key wake detection, analog switch control and legacy keypad pinout.
// Assumes a serial bus slave elsewhere delivers one-cycle byte read and write strobes.
`include "hkw_regs.svh"
`default_nettype none
module hkw_top
    import hkw_pkg::*;
#(
    parameter int NPINS = 24
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire hkw_reg_req_s         reg_req,
    output logic [7:0]                reg_rdata,
    output logic                      reg_hit,
    input  wire logic [NPINS-1:0]     pin_in,
    input  wire logic [NPINS-1:0]     pin_is_primary,
    input  wire logic [NPINS-1:0]     pin_direction,
    input  wire logic [NPINS-1:0]     rising_edge_enable,
    input  wire logic [NPINS-1:0]     falling_edge_enable,
    input  wire logic                 global_int_enable,
    input  wire logic [NPINS-1:0]     pin_int_enable,
    input  wire logic                 sleep_request,
    input  wire logic [NPINS-1:0]     status_clear,
    output logic [NPINS-1:0]          edge_status,
    output logic                      host_int,
    output logic                      asleep,
    output logic                      wake_event,
    output logic                      switch1_select_b,
    output logic                      switch1_enable,
    output logic                      switch2_select_b,
    output logic                      switch2_enable,
    input  wire hkw_keypad_s          keypad_native,
    output logic                      legacy_pinout_select,
    output hkw_keypad_s               keypad_ball_native,
    output hkw_keypad_s               keypad_ball_legacy
);
    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    logic [7:0] switch_ctrl_r;
    logic [7:0] legacy_ctrl_r;
    logic [7:0] rdata_r;

    wire hit_switch = (reg_req.addr == `HKW_OFS_SWITCH_CTRL);
    wire hit_legacy = (reg_req.addr == `HKW_OFS_LEGACY_CTRL);
    wire [7:0] rd_mux = hit_switch ? switch_ctrl_r :
                        hit_legacy ? legacy_ctrl_r : 8'h00;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            switch_ctrl_r <= `HKW_SWITCH_RESET;
            legacy_ctrl_r <= `HKW_LEGACY_RESET;
            rdata_r       <= 8'h00;
        end else begin
            if (reg_req.wr && hit_switch)
                switch_ctrl_r <= reg_req.wdata & `HKW_SWITCH_RW_MASK;
            if (reg_req.wr && hit_legacy)
                legacy_ctrl_r <= reg_req.wdata & `HKW_LEGACY_RW_MASK;
            if (reg_req.rd)
                rdata_r <= rd_mux;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_hit   = hit_switch | hit_legacy;

    // ------------------------------------------------------------
    // Analog switches and legacy pinout
    // ------------------------------------------------------------
    assign switch1_select_b = switch_ctrl_r[`HKW_SW1_SEL_BIT];
    assign switch1_enable   = ~switch_ctrl_r[`HKW_SW1_DIS_BIT];
    assign switch2_select_b = switch_ctrl_r[`HKW_SW2_SEL_BIT];
    assign switch2_enable   = ~switch_ctrl_r[`HKW_SW2_DIS_BIT];

    assign legacy_pinout_select = legacy_ctrl_r[`HKW_LEGACY_BIT];
    // Only the eight keypad signals move; the inactive ball set is held low.
    assign keypad_ball_native = legacy_pinout_select ? '0 : keypad_native;
    assign keypad_ball_legacy = legacy_pinout_select ? keypad_native : '0;

    // ------------------------------------------------------------
    // Wake-key detection
    // ------------------------------------------------------------
    logic [NPINS-1:0] rise;
    logic [NPINS-1:0] fall;
    logic [NPINS-1:0] status_r;

    // The sampling clock keeps running in sleep, so keys are seen in both modes.
    // Any level held across three clock edges is seen, far below the minimum pulse width.
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_sync
            hkw_pin_sync u_sync (
                .ref_clk (ref_clk),
                .rst     (rst),
                .pin_in  (pin_in[gi]),
                .level   (),
                .rise    (rise[gi]),
                .fall    (fall[gi])
            );
        end
    endgenerate

    wire [NPINS-1:0] key_armed = pin_is_primary & ~pin_direction;
    wire [NPINS-1:0] key_edge  = key_armed & ((rise & rising_edge_enable) |
                                              (fall & falling_edge_enable));
    wire [NPINS-1:0] key_int   = status_r & pin_int_enable &
                                 {NPINS{global_int_enable}};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            status_r <= '0;
        else
            status_r <= key_edge | (status_r & ~status_clear);
    end

    assign edge_status = status_r;

    // ------------------------------------------------------------
    // Sleep and wake
    // ------------------------------------------------------------
    hkw_power_e pwr_r;
    hkw_power_e pwr_nxt;
    logic       int_r;
    wire        any_key = |(key_edge & pin_int_enable) & global_int_enable;

    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            HKW_AWAKE:  if (sleep_request && !any_key) pwr_nxt = HKW_ASLEEP;
            HKW_ASLEEP: if (any_key) pwr_nxt = HKW_WAKING;
            HKW_WAKING: pwr_nxt = HKW_AWAKE;
            default:    pwr_nxt = HKW_AWAKE;
        endcase
    end

    // While asleep or waking the interrupt is held back until the device is awake.
    wire int_nxt = |key_int & (pwr_r == HKW_AWAKE);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwr_r <= HKW_AWAKE;
            int_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            int_r <= int_nxt;
        end
    end

    assign host_int   = int_r;
    assign asleep     = (pwr_r != HKW_AWAKE);
    assign wake_event = (pwr_r == HKW_WAKING);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_key_sets_status: assert property (@(posedge ref_clk) disable iff (rst)
        (key_edge != '0) |=> ((status_r & $past(key_edge)) == $past(key_edge)))
        else $error("Wake-key edge did not set its status bit.");

    a_unarmed_no_int: assert property (@(posedge ref_clk) disable iff (rst)
        (!global_int_enable && !$past(global_int_enable)) |=> !host_int)
        else $error("Interrupt raised with global mask disabled.");

    a_sleep_wakes: assert property (@(posedge ref_clk) disable iff (rst)
        (pwr_r == HKW_ASLEEP && any_key) |=> wake_event ##1 !asleep)
        else $error("Asleep device did not wake on a key.");

    a_wake_then_int: assert property (@(posedge ref_clk) disable iff (rst)
        (wake_event && (|key_int)) |=> ##1 host_int)
        else $error("No interrupt after wake from sleep.");

    a_sw1_select: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_req.wr && hit_switch) |=> switch1_select_b == $past(reg_req.wdata[0]))
        else $error("Switch 1 select does not follow its bit.");

    a_sw1_enable: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_req.wr && hit_switch) |=> switch1_enable == !$past(reg_req.wdata[1]))
        else $error("Switch 1 enable does not follow its bit.");

    a_sw2_select: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_req.wr && hit_switch) |=> switch2_select_b == $past(reg_req.wdata[2]))
        else $error("Switch 2 select does not follow its bit.");

    a_sw2_enable: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_req.wr && hit_switch) |=> switch2_enable == !$past(reg_req.wdata[3]))
        else $error("Switch 2 enable does not follow its bit.");

    a_legacy_upper_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_req.rd && hit_legacy) |=> reg_rdata[7:1] == 7'h00)
        else $error("Legacy register upper bits not zero.");

    a_legacy_route: assert property (@(posedge ref_clk) disable iff (rst)
        legacy_pinout_select |-> (keypad_ball_legacy == keypad_native && keypad_ball_native == '0))
        else $error("Legacy keypad routing wrong.");
endmodule
`default_nettype wire

// file: bench/hkw_host_model.sv
// Host side model: issues byte register writes and reads to the block.
// Assumes one-cycle strobes taken at the rising edge of ref_clk.
`default_nettype none
module hkw_host_model
    import hkw_pkg::*;
(
    input  wire logic       ref_clk,
    output var hkw_reg_req_s reg_req,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial reg_req = '0;
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        reg_req <= '0;
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// Testbench for the hot-key wake, switch control and legacy pinout block.
// Assumes the host model drives the register port.
`include "hkw_regs.svh"
`default_nettype none
module tb;
    import hkw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SW = `HKW_OFS_SWITCH_CTRL;
    localparam logic [7:0] LG = `HKW_OFS_LEGACY_CTRL;
    logic ref_clk, rst, reg_hit, host_int, asleep, wake_event, gie, slp_req, leg_sel;
    logic s1_b, s1_en, s2_b, s2_en;
    logic [7:0] reg_rdata, v;
    logic [23:0] pin_in, prim, dir, ren, fen, pie, clr, edge_status;
    hkw_reg_req_s reg_req;
    hkw_keypad_s kp, kp_nat, kp_leg;
    int err_count = 0;
    int samples_checked = 0;
    hkw_host_model host_u (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
    hkw_top dut_u (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .pin_in(pin_in), .pin_is_primary(prim), .pin_direction(dir),
        .rising_edge_enable(ren), .falling_edge_enable(fen), .global_int_enable(gie),
        .pin_int_enable(pie), .sleep_request(slp_req), .status_clear(clr), .edge_status(edge_status),
        .host_int(host_int), .asleep(asleep), .wake_event(wake_event), .switch1_select_b(s1_b),
        .switch1_enable(s1_en), .switch2_select_b(s2_b), .switch2_enable(s2_en), .keypad_native(kp),
        .legacy_pinout_select(leg_sel), .keypad_ball_native(kp_nat), .keypad_ball_legacy(kp_leg));
    // ------------------------------------------------------------
    // Shared checks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_regs();
        host_u.rd(SW, v); chk("switch reset", v, `HKW_SWITCH_RESET);
        host_u.rd(LG, v); chk("legacy reset", v, `HKW_LEGACY_RESET);
        for (int i = 0; i < 4; i++) begin
            host_u.wr(SW, 8'h01 << i);
            #1 chk("sw1 sel", s1_b, i == 0);
            chk("sw1 en", s1_en, i != 1);
            chk("sw2 sel", s2_b, i == 2);
            chk("sw2 en", s2_en, i != 3);
            host_u.rd(SW, v); chk("switch read", v, 8'h01 << i);
        end
        host_u.wr(SW, 8'hFF); host_u.rd(SW, v); chk("switch mask", v, `HKW_SWITCH_RW_MASK);
        host_u.wr(LG, 8'hFE); host_u.rd(LG, v); chk("legacy upper", v, 8'h00);
        host_u.wr(8'hA0, 8'hFF); host_u.rd(8'hA0, v); chk("unmapped", v, 8'h00);
    endtask
    task automatic test_legacy();
        @(posedge ref_clk) kp <= 8'h5A;
        repeat (2) @(posedge ref_clk);
        #1 chk("native balls", kp_nat, 8'h5A);
        chk("legacy balls", kp_leg, 8'h00);
        host_u.wr(LG, 8'hFF);
        #1 chk("legacy bit", leg_sel, 1'b1);
        chk("native off", kp_nat, 8'h00);
        chk("legacy on", kp_leg, 8'h5A);
        host_u.wr(LG, 8'h00);
    endtask
    task automatic test_edges();
        @(posedge ref_clk) prim <= 24'h2; dir <= 24'h2; ren <= 24'h2; fen <= '0; pin_in <= 24'h2;
        repeat (20) @(posedge ref_clk);
        #1 chk("output pin status", edge_status[1], 1'b0);
        @(posedge ref_clk) dir <= '0; ren <= '0; fen <= 24'h2; pin_in <= '0;
        repeat (20) @(posedge ref_clk);
        #1 chk("falling status", edge_status[1], 1'b1);
        @(posedge ref_clk) clr <= 24'h2;
        @(posedge ref_clk) clr <= '0; fen <= '0; prim <= '0;
        repeat (2) @(posedge ref_clk);
        #1 chk("falling cleared", edge_status[1], 1'b0);
    endtask
    task automatic wake_case(input logic s, input logic m, input logic p);
        logic si, sw;
        si = 0;
        sw = 0;
        @(posedge ref_clk);
        prim <= {23'h0, p}; dir <= '0; ren <= 24'h1; pie <= {23'h0, m}; gie <= 1'b1;
        slp_req <= s;
        repeat (4) @(posedge ref_clk);
        #1 chk("asleep", asleep, s);
        @(posedge ref_clk) pin_in <= 24'h1;
        slp_req <= 1'b0;
        repeat (7813) begin
            @(posedge ref_clk);
            #1 si |= host_int;
            sw |= wake_event;
        end
        @(posedge ref_clk) pin_in <= '0;
        #1 chk("status", edge_status[0], p);
        chk("interrupt", si, p & m);
        chk("wake", sw, s);
        chk("awake", asleep, 1'b0);
        @(posedge ref_clk) clr <= 24'h1;
        @(posedge ref_clk) clr <= '0;
        repeat (6) @(posedge ref_clk);
        #1 chk("cleared", {host_int, edge_status[0]}, 2'b00);
    endtask
    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        rst = 1; pin_in = '0; prim = '0; dir = '0; ren = '0; fen = '0; pie = '0; clr = '0;
        gie = 0; slp_req = 0; kp = '0;
        repeat (20) @(posedge ref_clk);
        rst <= 0;
        test_regs();
        test_legacy();
        test_edges();
        wake_case(0, 1, 1);
        wake_case(0, 0, 1);
        wake_case(0, 1, 0);
        wake_case(1, 1, 1);
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
